/* rtl/gptl_pkg.sv */
// Shared constants and carrier types of the output, preset and limit bank
package gptl_pkg;

   // ==========================================================
   // Register offsets
   // ==========================================================
   localparam logic [7:0] OFS_OUT_LOW = 8'h00; // Output levels, ports 0-15
   localparam logic [7:0] OFS_OUT_HIGH = 8'h01; // Output levels, ports 16-19
   localparam logic [7:0] OFS_PRESET_A = 8'h02; // First preset value
   localparam logic [7:0] OFS_PRESET_B = 8'h03; // Second preset value
   localparam logic [7:0] OFS_AVG_CFG = 8'h04; // Averaging configuration
   localparam logic [7:0] OFS_INT_UP = 8'h05; // Internal upper limit
   localparam logic [7:0] OFS_INT_LO = 8'h06; // Internal lower limit
   localparam logic [7:0] OFS_RA_UP = 8'h07; // Remote A upper limit
   localparam logic [7:0] OFS_RA_LO = 8'h08; // Remote A lower limit
   localparam logic [7:0] OFS_RB_UP = 8'h09; // Remote B upper limit
   localparam logic [7:0] OFS_RB_LO = 8'h0a; // Remote B lower limit
   localparam logic [7:0] OFS_INT_FLAGS = 8'h0b; // Internal temp flags
   localparam logic [7:0] OFS_RA_FLAGS = 8'h0c; // Remote A temp flags
   localparam logic [7:0] OFS_RB_FLAGS = 8'h0d; // Remote B temp flags

   // ==========================================================
   // Widths, fields and reset values
   // ==========================================================
   localparam int PORTS = 20; // Number of general ports
   localparam int MONS = 3; // Monitors: internal, remote A, remote B
   localparam int CODE_W = 12; // Temperature and preset width
   localparam int ACC_W = 18; // Signed sum of up to 32 codes
   localparam int CNT_W = 6; // Sample counter width
   localparam int CFG_W = 2; // Averaging code width per monitor
   localparam int FLAG_HIGH_BIT = 2; // Over-limit flag position
   localparam int FLAG_LOW_BIT = 1; // Under-limit flag position
   localparam logic [CNT_W-1:0] AVG_MIN = 6'h04; // Samples for code 00
   localparam logic [2:0] AVG_MIN_LOG2 = 3'h2; // Log2 of AVG_MIN
   localparam logic [15:0] RST_VALUE = 16'h0000; // Reset value of all regs

   // ==========================================================
   // Carrier types
   // ==========================================================
   // Host register request, one cycle per access
   typedef struct packed {
      logic wr; // Write strobe
      logic rd; // Read strobe
      logic [7:0] addr; // Register offset
      logic [15:0] wdata; // Write data
   } gptl_req_t;

   // Register read answer
   typedef struct packed {
      logic valid; // One-cycle answer pulse
      logic [15:0] data; // Read data
   } gptl_rsp_t;

   // One temperature conversion from a sensor front end
   typedef struct packed {
      logic valid; // One-cycle sample strobe
      logic [CODE_W-1:0] code; // Two's complement, 0.125 C per lsb
   } gptl_sample_t;

endpackage : gptl_pkg

/* rtl/gptl_regs.sv */
// Output level, preset and temperature limit register bank
// Notes
// Host, sensor strobes and enables all run on core_clk; no syncing.
// Pin levels are always driven; pin_oe picks the ports that use them.
// A read answer stands one cycle after its strobe; writes get none.
// A flag read clears that monitor's flags, but a limit crossing in
// the same cycle still leaves its flag set.
// A result equal to a limit sets no flag; both compares are strict.
// Disabling a monitor drops its partial sum, so a re-enabled monitor
// always starts a fresh average.
// The average is the floor of the signed sum, by arithmetic shift.
// Lowering the averaging code mid-run ends the current average as
// soon as the samples already taken reach the new count.
// Writes to flag registers and unmapped offsets are ignored, and
// unmapped offsets read as zero.
module gptl_regs
   import gptl_pkg::*;
(
   input wire logic core_clk,
   input wire logic srst,
   input wire gptl_pkg::gptl_req_t host_req,
   output gptl_pkg::gptl_rsp_t host_rsp,
   input wire logic [gptl_pkg::PORTS-1:0] port_is_output,
   input wire logic [gptl_pkg::MONS-1:0] monitor_enables,
   input wire gptl_pkg::gptl_sample_t [gptl_pkg::MONS-1:0] temp_sample,
   output logic [gptl_pkg::PORTS-1:0] pin_level,
   output logic [gptl_pkg::PORTS-1:0] pin_oe,
   output logic [gptl_pkg::CODE_W-1:0] dac_preset_first,
   output logic [gptl_pkg::CODE_W-1:0] dac_preset_second,
   output logic [gptl_pkg::MONS-1:0][gptl_pkg::CODE_W-1:0] temp_average,
   output logic [gptl_pkg::MONS-1:0][1:0] temp_flags
);
   import gptl_pkg::*;

   // ==========================================================
   // State
   // ==========================================================
   // Whole module state in one record
   typedef struct packed {
      logic [15:0] out_low; // Levels of ports 0-15
      logic [3:0] out_high; // Levels of ports 16-19
      logic [CODE_W-1:0] preset_a; // First preset
      logic [CODE_W-1:0] preset_b; // Second preset
      logic [5:0] avg_cfg; // Three 2-bit averaging codes
      logic [MONS-1:0][CODE_W-1:0] upper; // Upper limits
      logic [MONS-1:0][CODE_W-1:0] lower; // Lower limits
      logic [MONS-1:0][ACC_W-1:0] acc; // Running sums
      logic [MONS-1:0][CNT_W-1:0] cnt; // Samples taken so far
      logic [MONS-1:0][CODE_W-1:0] avg; // Last averaged result
      logic [MONS-1:0][1:0] flags; // {high, low} sticky flags
      logic [PORTS-1:0] level; // Registered pin levels
      logic [PORTS-1:0] oe; // Registered pin enables
      logic rvalid; // Read answer strobe
      logic [15:0] rdata; // Read answer data
   } gptl_state_t;

   gptl_state_t state_reg; // Current state
   gptl_state_t state_next; // Next state

   // ==========================================================
   // Helpers
   // ==========================================================
   // Samples to average for a 2-bit code
   // Code 00 gives the minimum count; each step doubles it
   function automatic logic [CNT_W-1:0] avg_target(input logic [1:0] c);
      avg_target = AVG_MIN << c;
   endfunction : avg_target

   // Zero-extend a 12-bit field to a register word
   // Upper four bits of a 12-bit register always read zero
   function automatic logic [15:0] word12(input logic [CODE_W-1:0] v);
      word12 = {4'h0, v};
   endfunction : word12

   // ==========================================================
   // Next-state logic
   // ==========================================================
   // Register access, averaging, limit checks and pin drive
   always_comb
   begin
      logic [ACC_W-1:0] sum;
      logic [ACC_W-1:0] shifted;
      logic [1:0] code;
      logic [2:0] shamt;
      sum = '0;
      shifted = '0;
      code = '0;
      shamt = '0;
      state_next = state_reg;
      state_next.rvalid = 1'b0;

      // Host writes; presets touch only themselves
      if (host_req.wr)
      begin
         case (host_req.addr)
            OFS_OUT_LOW:
            begin
               // Levels of ports 0 to 15
               state_next.out_low = host_req.wdata;
            end
            OFS_OUT_HIGH:
            begin
               // Levels of ports 16 to 19, upper bits dropped
               state_next.out_high = host_req.wdata[3:0];
            end
            OFS_PRESET_A:
            begin
               // First preset only; per-port data untouched
               state_next.preset_a = host_req.wdata[11:0];
            end
            OFS_PRESET_B:
            begin
               // Second preset only; per-port data untouched
               state_next.preset_b = host_req.wdata[11:0];
            end
            OFS_AVG_CFG:
            begin
               // Three 2-bit sample count codes
               state_next.avg_cfg = host_req.wdata[5:0];
            end
            OFS_INT_UP:
            begin
               // Internal upper limit, signed
               state_next.upper[0] = host_req.wdata[11:0];
            end
            OFS_INT_LO:
            begin
               // Internal lower limit, signed
               state_next.lower[0] = host_req.wdata[11:0];
            end
            OFS_RA_UP:
            begin
               // Remote A upper limit, signed
               state_next.upper[1] = host_req.wdata[11:0];
            end
            OFS_RA_LO:
            begin
               // Remote A lower limit, signed
               state_next.lower[1] = host_req.wdata[11:0];
            end
            OFS_RB_UP:
            begin
               // Remote B upper limit, signed
               state_next.upper[2] = host_req.wdata[11:0];
            end
            OFS_RB_LO:
            begin
               // Remote B lower limit, signed
               state_next.lower[2] = host_req.wdata[11:0];
            end
            default: ; // Flags and unmapped offsets ignore writes
         endcase
      end

      // Host reads, answer one cycle later
      if (host_req.rd)
      begin
         state_next.rvalid = 1'b1;
         case (host_req.addr)
            OFS_OUT_LOW:
            begin
               // Levels of ports 0 to 15
               state_next.rdata = state_reg.out_low;
            end
            OFS_OUT_HIGH:
            begin
               // Levels of ports 16 to 19 in the low nibble
               state_next.rdata = {12'h000, state_reg.out_high};
            end
            OFS_PRESET_A:
            begin
               // First preset in the low twelve bits
               state_next.rdata = word12(state_reg.preset_a);
            end
            OFS_PRESET_B:
            begin
               // Second preset in the low twelve bits
               state_next.rdata = word12(state_reg.preset_b);
            end
            OFS_AVG_CFG:
            begin
               // Three averaging codes in the low six bits
               state_next.rdata = {10'h000, state_reg.avg_cfg};
            end
            OFS_INT_UP:
            begin
               // Internal upper limit
               state_next.rdata = word12(state_reg.upper[0]);
            end
            OFS_INT_LO:
            begin
               // Internal lower limit
               state_next.rdata = word12(state_reg.lower[0]);
            end
            OFS_RA_UP:
            begin
               // Remote A upper limit
               state_next.rdata = word12(state_reg.upper[1]);
            end
            OFS_RA_LO:
            begin
               // Remote A lower limit
               state_next.rdata = word12(state_reg.lower[1]);
            end
            OFS_RB_UP:
            begin
               // Remote B upper limit
               state_next.rdata = word12(state_reg.upper[2]);
            end
            OFS_RB_LO:
            begin
               // Remote B lower limit
               state_next.rdata = word12(state_reg.lower[2]);
            end
            OFS_INT_FLAGS:
            begin
               // Internal flags as bits 2:1, then cleared
               state_next.rdata = {13'h0000, state_reg.flags[0], 1'b0};
               state_next.flags[0] = 2'b00;
            end
            OFS_RA_FLAGS:
            begin
               // Remote A flags as bits 2:1, then cleared
               state_next.rdata = {13'h0000, state_reg.flags[1], 1'b0};
               state_next.flags[1] = 2'b00;
            end
            OFS_RB_FLAGS:
            begin
               // Remote B flags as bits 2:1, then cleared
               state_next.rdata = {13'h0000, state_reg.flags[2], 1'b0};
               state_next.flags[2] = 2'b00;
            end
            default: state_next.rdata = RST_VALUE; // Unmapped reads zero
         endcase
      end

      // Per-monitor averaging and limit comparison
      // Each monitor keeps a running sum and a count of taken samples;
      // the sample that completes the count joins the sum before the
      // shift, so no extra cycle is spent on the division
      for (int m = 0; m < MONS; m++)
      begin
         // Averaging code of this monitor
         code = state_reg.avg_cfg[2*m +: CFG_W];
         // Shift that divides by the selected sample count
         shamt = AVG_MIN_LOG2 + {1'b0, code};
         // Running sum plus the sign-extended new sample
         sum = state_reg.acc[m]
            + {{(ACC_W-CODE_W){temp_sample[m].code[CODE_W-1]}},
               temp_sample[m].code};
         // Floor of the signed sum over the sample count
         shifted = ACC_W'($signed(sum) >>> shamt);
         if (!monitor_enables[m])
         begin
            // Disabled monitor holds no partial sum
            state_next.acc[m] = '0;
            state_next.cnt[m] = '0;
         end
         else if (temp_sample[m].valid)
         begin
            // Sample taken from an enabled monitor
            if (state_reg.cnt[m] + 6'h01 >= avg_target(code))
            begin
               // Average complete: store and compare once
               state_next.avg[m] = shifted[CODE_W-1:0];
               state_next.acc[m] = '0;
               state_next.cnt[m] = '0;
               // Signed compare; set wins over a read clear
               // A result equal to a limit sets nothing
               if ($signed(shifted[CODE_W-1:0])
                   > $signed(state_reg.upper[m]))
               begin
                  state_next.flags[m][FLAG_HIGH_BIT-1] = 1'b1;
               end
               if ($signed(shifted[CODE_W-1:0])
                   < $signed(state_reg.lower[m]))
               begin
                  state_next.flags[m][FLAG_LOW_BIT-1] = 1'b1;
               end
            end
            else
            begin
               // Still collecting samples
               state_next.acc[m] = sum;
               state_next.cnt[m] = state_reg.cnt[m] + 6'h01;
            end
         end
      end

      // Drive levels of output-configured ports
      // Every level is offered; pin_oe picks the ports that drive
      state_next.level = {state_reg.out_high, state_reg.out_low};
      state_next.oe = port_is_output;
   end

   // ==========================================================
   // State register
   // ==========================================================
   // Synchronous reset returns every register to its default
   // Reset loads constants only; no state is read in that branch
   // All defaults are zero, matching the register reset value
   always_ff @(posedge core_clk)
   begin
      if (srst)
      begin
         state_reg <= '0;
      end
      else
      begin
         state_reg <= state_next;
      end
   end

   // ==========================================================
   // Outputs, all straight from the state register
   // ==========================================================
   // Read answer: strobe for one cycle, data held until the next read
   assign host_rsp.valid = state_reg.rvalid;
   assign host_rsp.data = state_reg.rdata;
   // Pin drive, presets and monitor results
   assign pin_level = state_reg.level;
   assign pin_oe = state_reg.oe;
   assign dac_preset_first = state_reg.preset_a;
   assign dac_preset_second = state_reg.preset_b;
   assign temp_average = state_reg.avg;
   assign temp_flags = state_reg.flags;

endmodule : gptl_regs

/* verification/gptl_chk.sv */
// Concurrent checks of the bank, bound to its ports
module gptl_chk (
   input wire logic core_clk,
   input wire logic srst,
   input wire gptl_pkg::gptl_req_t host_req,
   input wire gptl_pkg::gptl_rsp_t host_rsp,
   input wire logic [19:0] port_is_output,
   input wire logic [2:0] monitor_enables,
   input wire gptl_pkg::gptl_sample_t [2:0] temp_sample,
   input wire logic [19:0] pin_level,
   input wire logic [19:0] pin_oe,
   input wire logic [11:0] dac_preset_first,
   input wire logic [2:0][11:0] temp_average,
   input wire logic [2:0][1:0] temp_flags
);
   timeunit 1ns;
   timeprecision 1ps;
   import gptl_pkg::*;
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (srst);
   // Low level write, then a cycle without one
   sequence s_lvl;
      host_req.wr && host_req.addr == OFS_OUT_LOW
      ##1 !(host_req.wr && host_req.addr == OFS_OUT_LOW);
   endsequence
   // Remote A flag read with no sample in flight
   sequence s_rd_a;
      host_req.rd && host_req.addr == OFS_RA_FLAGS
      && !temp_sample[1].valid && !$past(temp_sample[1].valid);
   endsequence
   a_rsp_after_read:
   assert property (host_req.rd |=> host_rsp.valid)
      else $error("Read answer missing");
   a_no_stray_rsp:
   assert property (!host_req.rd |=> !host_rsp.valid)
      else $error("Read answer without read");
   a_unmapped_zero:
   assert property (host_req.rd && host_req.addr == 8'h20
      |=> host_rsp.data == 16'h0000) else $error("Unmapped read not zero");
   a_oe_follows_cfg:
   assert property (!$past(srst) |-> pin_oe == $past(port_is_output))
      else $error("Drive enable wrong");
   a_level_write:
   assert property (s_lvl |=> pin_level[15:0] == $past(host_req.wdata, 2))
      else $error("Pin levels do not follow write");
   a_preset_write:
   assert property (host_req.wr && host_req.addr == OFS_PRESET_A
      |=> dac_preset_first == $past(host_req.wdata[11:0]))
      else $error("Preset not updated");
   a_flags_sticky:
   assert property (!(host_req.rd && host_req.addr == OFS_INT_FLAGS)
      |=> (temp_flags[0] & $past(temp_flags[0])) == $past(temp_flags[0]))
      else $error("Flag dropped without read");
   a_flag_clear:
   assert property (s_rd_a |=> temp_flags[1] == 2'b00)
      else $error("Flag not cleared by read");
   a_disabled_quiet:
   assert property ((!monitor_enables[2])[*3] |=> $stable(temp_average[2]))
      else $error("Disabled monitor moved");
endmodule : gptl_chk
bind gptl_regs gptl_chk u_chk (.core_clk, .srst, .host_req, .host_rsp,
   .port_is_output, .monitor_enables, .temp_sample, .pin_level, .pin_oe,
   .dac_preset_first, .temp_average, .temp_flags);

/* verification/gptl_host.sv */
// Host model that issues register accesses to the bank
module gptl_host (
   input wire logic core_clk,
   input wire gptl_pkg::gptl_rsp_t host_rsp,
   output gptl_pkg::gptl_req_t host_req
);
   timeunit 1ns;
   timeprecision 1ps;
   import gptl_pkg::*;
   // Idle request from time zero
   initial host_req = '0;
   // One-cycle write strobe, launched off the falling edge
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      @(negedge core_clk);
      host_req <= '{1'b1, 1'b0, a, d};
      @(negedge core_clk);
      host_req <= '0;
   endtask : wr
   // One-cycle read strobe; answer and its valid taken a cycle on
   task automatic rd(input logic [7:0] a, output logic [16:0] r);
      @(negedge core_clk);
      host_req <= '{1'b0, 1'b1, a, 16'h0000};
      @(negedge core_clk);
      host_req <= '0;
      r = {host_rsp.valid, host_rsp.data};
   endtask : rd
endmodule : gptl_host

/* verification/tb_gptl_regs.sv */
// Self-checking bench of the output, preset and limit register bank
`define CHK(n, e, g) \
   begin \
      comparisons++; \
      if ((g) !== (e)) \
      begin \
         error_cnt++; \
         $display("Error %s: expected %h, seen %h", n, e, g); \
      end \
   end
module tb_gptl_regs;
   timeunit 1ns;
   timeprecision 1ps;
   import gptl_pkg::*;
   // Row: offset, value written, value read back
   typedef struct packed {
      logic [7:0] a;
      logic [15:0] d;
      logic [15:0] e;
   } gptl_row_t;
   localparam gptl_row_t ROWS [9] = '{'{OFS_OUT_LOW, 16'ha5c3, 16'ha5c3},
      '{OFS_OUT_HIGH, 16'hfffa, 16'h000a}, '{OFS_PRESET_A, 16'hf123, 16'h0123},
      '{OFS_PRESET_B, 16'h7fed, 16'h0fed}, '{OFS_AVG_CFG, 16'h0036, 16'h0036},
      '{OFS_INT_UP, 16'hf800, 16'h0800}, '{OFS_RB_LO, 16'h87ff, 16'h07ff},
      '{OFS_INT_FLAGS, 16'hffff, 16'h0000}, '{8'h20, 16'hffff, 16'h0000}};
   // Sample base per code; its average lands one above it
   localparam logic [11:0] BASE [4] = '{12'h010, 12'hfee, 12'h00f, 12'hfef};
   localparam logic [15:0] FLAGS [4] = '{16'h4, 16'h2, 16'h0, 16'h0};
   logic core_clk = 1'b0;
   logic srst = 1'b1;
   gptl_req_t host_req;
   gptl_rsp_t host_rsp;
   logic [19:0] port_is_output = '0;
   logic [2:0] monitor_enables = '0;
   gptl_sample_t [2:0] temp_sample = '0;
   gptl_sample_t smp;
   logic [19:0] pin_level, pin_oe;
   logic [11:0] dac_preset_first, dac_preset_second;
   logic [2:0][11:0] temp_average;
   logic [2:0][1:0] temp_flags;
   logic [16:0] rsp;
   int n;
   int error_cnt = 0;
   int comparisons = 0;
   // 40 MHz clock
   always #12.5 core_clk = ~core_clk;
   gptl_regs DUT (.core_clk, .srst, .host_req, .host_rsp, .port_is_output,
      .monitor_enables, .temp_sample, .pin_level, .pin_oe, .dac_preset_first,
      .dac_preset_second, .temp_average, .temp_flags);
   gptl_host host (.core_clk, .host_rsp, .host_req);
   // Counts, verdict and end of run
   task automatic complete_run();
      $display("Comparisons %0d, errors %0d", comparisons, error_cnt);
      if (error_cnt == 0 && comparisons > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : complete_run
   // Watchdog, far past the expected 336 cycles
   initial
   begin
      #200000;
      error_cnt++;
      complete_run();
   end
   // Main sequence
   initial
   begin
      repeat (5) @(negedge core_clk);
      srst = 1'b0;
      port_is_output = 20'haaaaa;
      foreach (ROWS[i])
      begin
         host.wr(ROWS[i].a, ROWS[i].d);
         host.rd(ROWS[i].a, rsp);
         `CHK("read back", {1'b1, ROWS[i].e}, rsp)
      end
      `CHK("levels", {4'ha, 16'ha5c3}, pin_level)
      `CHK("enables", 20'haaaaa, pin_oe)
      `CHK("presets", 24'h123fed, {dac_preset_first, dac_preset_second})
      for (int m = 0; m < 3; m++)
      begin
         host.wr(OFS_INT_UP + 8'(2 * m), 16'h0010);
         host.wr(OFS_INT_LO + 8'(2 * m), 16'h0ff0);
         for (int c = 0; c < 4; c++)
         begin
            // Restart only monitor m; the others see the same samples
            monitor_enables = '0;
            host.wr(OFS_AVG_CFG, 16'(c << (2 * m)));
            monitor_enables[m] = 1'b1;
            n = 4 << c;
            for (int i = 0; i < n; i++)
            begin
               @(negedge core_clk);
               smp.valid = 1'b1;
               smp.code = (i == n - 1) ? BASE[c] + 12'(n) : BASE[c];
               temp_sample = {3{smp}};
            end
            @(negedge core_clk);
            temp_sample = '0;
            @(negedge core_clk);
            `CHK("average", BASE[c] + 12'h001, temp_average[m])
            `CHK("idle flags", 6'h0, temp_flags & ~(6'h3 << (2 * m)))
            host.rd(OFS_INT_FLAGS + 8'(m), rsp);
            `CHK("flags", {1'b1, FLAGS[c]}, rsp)
            host.rd(OFS_INT_FLAGS + 8'(m), rsp);
            `CHK("cleared", 17'h10000, rsp)
         end
      end
      // Reset in mid-run
      srst = 1'b1;
      repeat (5) @(negedge core_clk);
      srst = 1'b0;
      `CHK("reset levels", 20'h00000, pin_level)
      `CHK("reset state", 62'h0, {pin_oe, temp_average, temp_flags})
      host.rd(OFS_PRESET_A, rsp);
      `CHK("reset preset", 17'h10000, rsp)
      complete_run();
   end
endmodule : tb_gptl_regs
